// ===== sclrg_top.v
// scl rate generator: clock-rate registers, sm/fm/fm+ channel 0 timing, two ufm clocks
`timescale 1ns/1ps
`include "sclrg_defines.vh"

module sclrg_top
(
  // clock and reset; clk_i is the pll clock
  input  wire       clk_i,
  input  wire       rst_n_i,
  // host parallel register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output wire [7:0] rdata_o,
  // channel enables
  input  wire       ch0_en_i,
  input  wire [1:0] ufm_en_i,
  // channel 0 open-drain scl
  input  wire       scl0_i,
  output wire       scl0_o,
  output wire       scl0_oe_o,
  // ufm clocks and data delays
  output wire [1:0] ufm_scl_o,
  output wire [5:0] ufm_data_delay1_o,
  output wire [5:0] ufm_data_delay2_o
);

  localparam [2:0] ST_LOW  = 3'b001;
  localparam [2:0] ST_RISE = 3'b010;
  localparam [2:0] ST_HIGH = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function [10:0] scale_cnt;
    input [7:0] c;
    input [1:0] m;
    begin
      case (m)
        `SCLRG_MODE_SM:  scale_cnt = {c, 3'b000};
        `SCLRG_MODE_FM:  scale_cnt = {1'b0, c, 2'b00};
        default:         scale_cnt = {3'b000, c};
      endcase
    end
  endfunction

  function [10:0] max11;
    input [10:0] a;
    input [10:0] b;
    begin
      max11 = (a > b) ? a : b;
    end
  endfunction

  function [7:0] min_cnt;
    input [1:0] m;
    input       hi;
    begin
      case (m)
        `SCLRG_MODE_SM:  min_cnt = hi ? `SCLRG_MIN_HIGH_SM : `SCLRG_MIN_LOW_SM;
        `SCLRG_MODE_FM:  min_cnt = hi ? `SCLRG_MIN_HIGH_FM : `SCLRG_MIN_LOW_FM;
        default:         min_cnt = hi ? `SCLRG_MIN_HIGH_FMP : `SCLRG_MIN_LOW_FMP;
      endcase
    end
  endfunction

  function [5:0] clamp_dly;
    input [5:0] d;
    begin
      clamp_dly = (d < `SCLRG_MIN_DLY) ? `SCLRG_MIN_DLY : d;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg  [7:0] scl_low_count_q;
  reg  [7:0] scl_high_count_q;
  reg  [1:0] mode_q;
  reg  [7:0] ufm_period_ch1_q;
  reg  [7:0] ufm_period_ch2_q;
  reg  [5:0] ufm_data_delay1_q;
  reg  [5:0] ufm_data_delay2_q;
  reg  [7:0] rdata_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_low_count_q   <= `SCLRG_RST_LOW;
      scl_high_count_q  <= `SCLRG_RST_HIGH;
      mode_q            <= `SCLRG_RST_MODE;
      ufm_period_ch1_q  <= `SCLRG_RST_PER;
      ufm_period_ch2_q  <= `SCLRG_RST_PER;
      ufm_data_delay1_q <= `SCLRG_RST_DLY;
      ufm_data_delay2_q <= `SCLRG_RST_DLY;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `SCLRG_ADDR_LOW0:  scl_low_count_q  <= wdata_i;
        `SCLRG_ADDR_HIGH0: scl_high_count_q <= wdata_i;
        `SCLRG_ADDR_MODE0: mode_q           <= wdata_i[1:0];
        `SCLRG_ADDR_PER1:
        begin
          ufm_period_ch1_q  <= wdata_i;
          ufm_data_delay1_q <= wdata_i[7:2];
        end
        `SCLRG_ADDR_PER2:
        begin
          ufm_period_ch2_q  <= wdata_i;
          ufm_data_delay2_q <= wdata_i[7:2];
        end
        `SCLRG_ADDR_DLY1:  ufm_data_delay1_q <= wdata_i[5:0];
        `SCLRG_ADDR_DLY2:  ufm_data_delay2_q <= wdata_i[5:0];
        default:           mode_q <= mode_q;
      endcase
    end
  end

  // read data registered; unmapped addresses read zero
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `SCLRG_ADDR_LOW0:  rdata_q <= scl_low_count_q;
        `SCLRG_ADDR_HIGH0: rdata_q <= scl_high_count_q;
        `SCLRG_ADDR_MODE0: rdata_q <= {6'h00, mode_q};
        `SCLRG_ADDR_PER1:  rdata_q <= ufm_period_ch1_q;
        `SCLRG_ADDR_PER2:  rdata_q <= ufm_period_ch2_q;
        `SCLRG_ADDR_DLY1:  rdata_q <= {2'b00, ufm_data_delay1_q};
        `SCLRG_ADDR_DLY2:  rdata_q <= {2'b00, ufm_data_delay2_q};
        default:           rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata_o           = rdata_q;
  assign ufm_data_delay1_o = clamp_dly(ufm_data_delay1_q);
  assign ufm_data_delay2_o = clamp_dly(ufm_data_delay2_q);

  ////////////////////////////////////////////////////////////////////////
  // scl pin sampling; first flop feeds only the second

  reg scl_s1_q;
  reg scl_s2_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= scl0_i;
      scl_s2_q <= scl_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel 0 phase timing, all in pll cycles

  wire [10:0] min_low_c;
  wire [10:0] min_high_c;
  wire [10:0] eff_low_c;
  wire [10:0] eff_high_c;
  wire [10:0] trim_low_c;
  wire [10:0] tgt_low_c;

  assign min_low_c  = scale_cnt(min_cnt(mode_q, 1'b0), mode_q);
  assign min_high_c = scale_cnt(min_cnt(mode_q, 1'b1), mode_q);
  assign eff_low_c  = max11(scale_cnt(scl_low_count_q, mode_q), min_low_c);
  assign eff_high_c = max11(scale_cnt(scl_high_count_q, mode_q), min_high_c);

  reg [2:0]  state_q;
  reg [10:0] cnt_q;
  reg [10:0] rise_q;

  // measured rise is taken out of the next low phase, floored at minimum
  assign trim_low_c = (eff_low_c > rise_q) ? (eff_low_c - rise_q) : 11'h000;
  assign tgt_low_c  = max11(trim_low_c, min_low_c);

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_HIGH;
      cnt_q   <= 11'h000;
      rise_q  <= 11'h000;
    end
    else if (!ch0_en_i)
    begin
      state_q <= ST_HIGH;
      cnt_q   <= 11'h000;
      rise_q  <= 11'h000;
    end
    else
    begin
      case (state_q)
        ST_LOW:
        begin
          if (cnt_q >= tgt_low_c - 11'h001)
          begin
            state_q <= ST_RISE;
            cnt_q   <= 11'h000;
            rise_q  <= 11'h000;
          end
          else
            cnt_q <= cnt_q + 11'h001;
        end
        ST_RISE:
        begin
          // high time starts only once the line is seen high
          if (scl_s2_q)
            state_q <= ST_HIGH;
          else if (rise_q != 11'h7FF)
            rise_q <= rise_q + 11'h001;
        end
        ST_HIGH:
        begin
          if (cnt_q >= eff_high_c - 11'h001)
          begin
            state_q <= ST_LOW;
            cnt_q   <= 11'h000;
          end
          else
            cnt_q <= cnt_q + 11'h001;
        end
        default:
        begin
          state_q <= ST_HIGH;
          cnt_q   <= 11'h000;
        end
      endcase
    end
  end

  reg scl0_oe_q;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      scl0_oe_q <= 1'b0;
    else
      scl0_oe_q <= ch0_en_i && (state_q == ST_LOW);
  end

  assign scl0_o    = 1'b0;
  assign scl0_oe_o = scl0_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // ufm channels

  sclrg_ufm_clk u_ufm1
  (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .en_i     (ufm_en_i[0]),
    .period_i (ufm_period_ch1_q),
    .scl_o    (ufm_scl_o[0])
  );

  sclrg_ufm_clk u_ufm2
  (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .en_i     (ufm_en_i[1]),
    .period_i (ufm_period_ch2_q),
    .scl_o    (ufm_scl_o[1])
  );

endmodule

// ===== sclrg_defines.vh
// register map, reset values and timing limits of the scl rate generator
`ifndef SCLRG_DEFINES_VH
`define SCLRG_DEFINES_VH

`define SCLRG_ADDR_LOW0     8'hCB
`define SCLRG_ADDR_HIGH0    8'hCC
`define SCLRG_ADDR_MODE0    8'hCD
`define SCLRG_ADDR_PER1     8'hDB
`define SCLRG_ADDR_DLY1     8'hDC
`define SCLRG_ADDR_PER2     8'hEB
`define SCLRG_ADDR_DLY2     8'hEC

`define SCLRG_RST_LOW       8'h5E
`define SCLRG_RST_HIGH      8'h3F
`define SCLRG_RST_PER       8'h20
`define SCLRG_RST_DLY       6'h08

`define SCLRG_MODE_SM       2'h0
`define SCLRG_MODE_FM       2'h1
`define SCLRG_MODE_FMP      2'h2
`define SCLRG_RST_MODE      2'h2

// pll clock nominal rate and multiplier of the oscillator
`define SCLRG_PLL_MHZ       156
`define SCLRG_PLL_MULT      13

// smallest legal counts per mode before scaling, then the ufm period and data delay floors
`define SCLRG_MIN_LOW_SM    8'h74
`define SCLRG_MIN_HIGH_SM   8'h4F
`define SCLRG_MIN_LOW_FM    8'h3A
`define SCLRG_MIN_HIGH_FM   8'h27
`define SCLRG_MIN_LOW_FMP   8'h5A
`define SCLRG_MIN_HIGH_FMP  8'h3F
`define SCLRG_MIN_PER       8'h20
`define SCLRG_MIN_DLY       6'h02

`endif

// ===== sclrg_ufm_clk.v
// fixed 50 percent duty clock generator for one ultra fast-mode channel
`timescale 1ns/1ps
`include "sclrg_defines.vh"

module sclrg_ufm_clk
(
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // control
  input  wire       en_i,
  input  wire [7:0] period_i,
  // push-pull clock out
  output wire       scl_o
);

  reg  [6:0] cnt_q;
  reg        scl_q;
  wire [7:0] per_c;
  wire [6:0] half_c;

  assign per_c  = (period_i < `SCLRG_MIN_PER) ? `SCLRG_MIN_PER : period_i;
  assign half_c = per_c[7:1];
  assign scl_o  = scl_q;

  ////////////////////////////////////////////////////////////////////////
  // disabled channel parks the line high
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 7'h00;
      scl_q <= 1'b1;
    end
    else if (!en_i)
    begin
      cnt_q <= 7'h00;
      scl_q <= 1'b1;
    end
    else if (cnt_q >= half_c - 7'h01)
    begin
      cnt_q <= 7'h00;
      scl_q <= ~scl_q;
    end
    else
    begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

endmodule

// ===== sclrg_bus_model.sv
// pull-up and load model on the channel 0 scl line
`timescale 1ns/1ps
module sclrg_bus_model
#(
  parameter RISE_NS = 160
)
(
  // line drive and level
  input  wire oe_i,
  output reg  scl_o
);
  // a released line climbs through the pull-up, so high comes late
  initial scl_o = 1'h1;
  always @(oe_i)
    if (oe_i)
      scl_o = 1'h0;
    else
      scl_o <= #(RISE_NS) 1'h1;
endmodule

// ===== sclrg_chk.sv
// port assertions of the scl rate generator
`timescale 1ns/1ps
module sclrg_chk
(
  // clock and reset
  input wire       clk_i,
  input wire       rst_n_i,
  // host port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  // channels
  input wire       ch0_en_i,
  input wire [1:0] ufm_en_i,
  input wire       scl0_i,
  input wire       scl0_o,
  input wire       scl0_oe_o,
  input wire [1:0] ufm_scl_o,
  input wire [5:0] ufm_data_delay1_o,
  input wire [5:0] ufm_data_delay2_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reg  [7:0]  per_q, h_q;
  reg  [1:0]  md_q;
  reg  [11:0] lc_q, oc_q, hc_q;
  wire [11:0] s    = md_q == 2'h0 ? 12'h8 : md_q == 2'h1 ? 12'h4 : 12'h1;
  wire [11:0] ml   = md_q == 2'h0 ? 12'h74 : md_q == 2'h1 ? 12'h3A : 12'h5A;
  wire [7:0]  mh   = md_q == 2'h0 ? 8'h4F : md_q == 2'h1 ? 8'h27 : 8'h3F;
  wire [11:0] hs   = (h_q < mh ? mh : h_q) * s;
  wire [7:0]  half = (per_q < 8'h20 ? 8'h20 : per_q) >> 1;
  function automatic [5:0] dly(input [7:0] w);
    dly = w[7:2] < 6'h02 ? 6'h02 : w[7:2];
  endfunction
  //////////////////////////////////////////////////
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      per_q <= 8'h20;
      h_q   <= 8'h3F;
      md_q  <= 2'h2;
      lc_q  <= 12'h0;
      oc_q  <= 12'h0;
      hc_q  <= 12'h0;
    end
    else
    begin
      if (wr_i && addr_i == 8'hDB)
        per_q <= wdata_i;
      if (wr_i && addr_i == 8'hCC)
        h_q <= wdata_i;
      if (wr_i && addr_i == 8'hCD)
        md_q <= wdata_i[1:0];
      lc_q <= (ufm_scl_o[0] || !ufm_en_i[0]) ? 12'h0 : lc_q + 12'h1;
      oc_q <= scl0_oe_o ? oc_q + 12'h1 : 12'h0;
      // high time counted only once the line is seen high
      hc_q <= (scl0_oe_o || !ch0_en_i || !scl0_i) ? 12'h0 : hc_q + 12'h1;
    end
  a_open_drain:
    assert property (scl0_o == 1'h0 && (!scl0_oe_o || $past(ch0_en_i)))
    else $error("scl0 data not low or pulled while off");
  a_low_floor:
    assert property ($fell(scl0_oe_o) && ch0_en_i |-> oc_q >= ml * s)
    else $error("scl0 low phase too short");
  a_high_time:
    assert property ($rose(scl0_oe_o) && ch0_en_i |-> hc_q >= hs && hc_q <= hs + 12'h4)
    else $error("scl0 high phase length wrong");
  a_ch0_released:
    assert property (!ch0_en_i [*2] |-> !scl0_oe_o) else $error("scl0 pulled while off");
  a_ufm_half:
    assert property ($rose(ufm_scl_o[0]) && $past(ufm_en_i[0]) |-> lc_q == half)
    else $error("ufm low level not half period");
  a_ufm_park:
    assert property (!ufm_en_i[1] [*2] |-> ufm_scl_o[1]) else $error("ufm clock not parked");
  a_delay_load1:
    assert property (wr_i && addr_i == 8'hDB |=> ufm_data_delay1_o == dly($past(wdata_i)))
    else $error("delay 1 not loaded");
  a_delay_load2:
    assert property (wr_i && addr_i == 8'hEB |=> ufm_data_delay2_o == dly($past(wdata_i)))
    else $error("delay 2 not loaded");
  a_period_back:
    assert property (wr_i && addr_i == 8'hDB ##1 rd_i && !wr_i && addr_i == 8'hDB
      |=> rdata_o == $past(wdata_i, 2)) else $error("period read back wrong");
  a_unmapped_zero:
    assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  cover property ($rose(scl0_oe_o));
  cover property ($rose(ufm_scl_o[1]));
  cover property (wr_i && addr_i == 8'hEB);
endmodule
bind sclrg_top sclrg_chk i_chk (.*);

// ===== sclrg_top_tb.sv
// self-checking bench of the scl rate generator
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module sclrg_top_tb;
  reg        clk_i = 1'h0, rst_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, ch0_en_i = 1'h0;
  reg  [7:0] addr_i = 8'h00, wdata_i = 8'h00, q;
  reg  [1:0] ufm_en_i = 2'h0;
  wire       scl0_i, scl0_o, scl0_oe_o;
  wire [7:0] rdata_o;
  wire [1:0] ufm_scl_o;
  wire [5:0] ufm_data_delay1_o, ufm_data_delay2_o;
  wire [2:0] lvl = {ufm_scl_o, ~scl0_oe_o};
  int        n_mismatch = 0, checks_done = 0, cyc = 0, n;
  sclrg_top i_dut (.*);
  sclrg_bus_model i_bus (.oe_i(scl0_oe_o), .scl_o(scl0_i));
  always #2 clk_i = ~clk_i;
  //////////////////////////////////////////////////
  // strobes stay up across back-to-back requests
  task automatic wr(input [7:0] a, input [7:0] d);
    rd_i = 1'h0;
    wr_i = 1'h1;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
  endtask
  task automatic rd(input [7:0] a);
    wr_i = 1'h0;
    rd_i = 1'h1;
    addr_i = a;
    @(negedge clk_i);
    q = rdata_o;
  endtask
  task automatic low_len(input int c);
    int k;
    k = 0;
    n = 0;
    wr_i = 1'h0;
    rd_i = 1'h0;
    while (lvl[c] !== 1'h1 && k < 9999)
    begin
      @(negedge clk_i);
      k++;
    end
    while (lvl[c] !== 1'h0 && k < 9999)
    begin
      @(negedge clk_i);
      k++;
    end
    while (lvl[c] === 1'h0 && n < 9999)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic t_regs;
    rd(8'hCB);
    `CHK(q, 8'h5E)
    rd(8'hCC);
    `CHK(q, 8'h3F)
    rd(8'hCD);
    `CHK(q, 8'h02)
    rd(8'hEB);
    `CHK(q, 8'h20)
    `CHK(ufm_data_delay1_o, 6'h08)
    wr(8'h00, 8'h5A);
    rd(8'h00);
    `CHK(q, 8'h00)
  endtask
  task automatic t_period;
    wr(8'hDB, 8'h40);
    `CHK(ufm_data_delay1_o, 6'h10)
    rd(8'hDB);
    `CHK(q, 8'h40)
    wr(8'hDC, 8'h3F);
    `CHK(ufm_data_delay1_o, 6'h3F)
    wr(8'hEB, 8'h04);
    `CHK(ufm_data_delay2_o, 6'h02)
    rd(8'hEB);
    `CHK(q, 8'h04)
  endtask
  task automatic t_ufm;
    wr(8'hDB, 8'h28);
    ufm_en_i = 2'h3;
    low_len(1);
    `CHK(n, 20)
    low_len(2);
    `CHK(n, 16)
    ufm_en_i = 2'h0;
  endtask
  task automatic t_ch0;
    int ex[4] = '{928, 232, 90, 90};
    for (int m = 0; m < 4; m++)
    begin
      ch0_en_i = 1'h0;
      // mode goes in before the counts
      wr(8'hCD, m[7:0]);
      wr(8'hCB, 8'h01);
      wr(8'hCC, 8'h01);
      // restart only once the released line is back high, else high looks short
      while (scl0_i !== 1'h1)
        @(negedge clk_i);
      ch0_en_i = 1'h1;
      low_len(0);
      `CHK(n, ex[m])
    end
    wr(8'hCD, 8'h02);
    wr(8'hCB, 8'h5E);
    wr(8'hCC, 8'h3F);
    low_len(0);
    low_len(0);
    `CHK(n, 90)
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      complete_run;
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'h1;
    t_regs;
    t_period;
    t_ufm;
    t_ch0;
    complete_run;
  end
endmodule
